// ### prio_pkg.sv
// Package with register map, field layout and types of the priority register bank.
package prio_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_CAN1_SPI2        = 12'h000;
   localparam logic [11:0] OFS_CAPTURE_DMA3     = 12'h004;
   localparam logic [11:0] OFS_COMPARE_CAPTURE6 = 12'h008;
   localparam logic [11:0] OFS_TIMER6_DMA4_CMP8 = 12'h00c;
   localparam logic [11:0] OFS_TIMERS_I2C2      = 12'h010;
   localparam int          NUM_REGS             = 5;
   localparam int          REG_W                = 16;
   localparam int          FIELD_W              = 3;
   localparam int          FIELDS_PER_REG       = 4;

   // ---------------------------------------------------------------
   // Field positions, masks and reset values
   // ---------------------------------------------------------------
   localparam int FIELD_POS0 = 0;
   localparam int FIELD_POS1 = 4;
   localparam int FIELD_POS2 = 8;
   localparam int FIELD_POS3 = 12;
   localparam logic [15:0] MASK_FULL      = 16'h7777;
   localparam logic [15:0] MASK_TIMER6    = 16'h7707;
   localparam logic [15:0] RESET_FULL     = 16'h4444;
   localparam logic [15:0] RESET_TIMER6   = 16'h4404;
   localparam logic [2:0]  LEVEL_DISABLED = 3'h0;
   localparam logic [2:0]  LEVEL_RESET    = 3'h4;
   localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

   // Priority levels of every source, as delivered to the arbiter.
   typedef struct packed {
      logic [2:0] can1_event_level;
      logic [2:0] can1_receive_level;
      logic [2:0] spi_port2_event_level;
      logic [2:0] spi_port2_error_level;
      logic [2:0] capture5_level;
      logic [2:0] capture4_level;
      logic [2:0] capture3_level;
      logic [2:0] dma_ch3_done_level;
      logic [2:0] compare7_level;
      logic [2:0] compare6_level;
      logic [2:0] compare5_level;
      logic [2:0] capture6_level;
      logic [2:0] timer6_level;
      logic [2:0] dma_ch4_done_level;
      logic [2:0] compare8_level;
      logic [2:0] timer8_level;
      logic [2:0] i2c_port2_master_level;
      logic [2:0] i2c_port2_slave_level;
      logic [2:0] timer7_level;
   } prio_levels_t;

   // Enable flags: a source requests service only with a nonzero level.
   typedef struct packed {
      logic can1_event;
      logic can1_receive;
      logic spi_port2_event;
      logic spi_port2_error;
      logic capture5;
      logic capture4;
      logic capture3;
      logic dma_ch3_done;
      logic compare7;
      logic compare6;
      logic compare5;
      logic capture6;
      logic timer6;
      logic dma_ch4_done;
      logic compare8;
      logic timer8;
      logic i2c_port2_master;
      logic i2c_port2_slave;
      logic timer7;
   } prio_enables_t;

endpackage

// ### prio_regs.sv
// Priority register bank for nineteen interrupt sources, reached over APB.
`timescale 1ns/1ps

// Behaviour
// - Each field is three bits, and values 1 to 7 are ascending levels with 7 highest.
// - A field holding zero disables its source so it never requests service.
// - Unimplemented bits ignore writes and read as zero.
// - After reset every implemented field holds 100, level 4.
// - Implemented field bits are read/write and read back the last value written.
// - Register 0 bits 14-12 hold the CAN 1 event level and 10-8 the CAN 1 receive level.
// - Register 0 bits 6-4 hold the SPI 2 event level and 2-0 the SPI 2 error level.
// - Register 1 holds captures 5, 4, 3 in the upper three fields and DMA 3 in bits 2-0.
// - Register 2 holds compares 7, 6, 5 in the upper three fields and capture 6 in bits 2-0.
// - Register 3 holds timer 6, DMA 4 in bits 14-8, compare 8 in 2-0, bits 7-3 empty.
// - Register 4 holds timer 8, I2C 2 master, I2C 2 slave and timer 7 from top to bottom.
module prio_regs
   import prio_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   output prio_levels_t       levels,
   output prio_enables_t      enables
);

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------

   // Maps a byte address to a one-hot register select; unmapped gives zero.
   function automatic logic [NUM_REGS-1:0] decode(input logic [11:0] addr);
      logic [NUM_REGS-1:0] sel;
      sel = '0;
      case (addr)
         OFS_CAN1_SPI2:        sel = 5'b00001;
         OFS_CAPTURE_DMA3:     sel = 5'b00010;
         OFS_COMPARE_CAPTURE6: sel = 5'b00100;
         OFS_TIMER6_DMA4_CMP8: sel = 5'b01000;
         OFS_TIMERS_I2C2:      sel = 5'b10000;
         default:              sel = 5'b00000;
      endcase
      return sel;
   endfunction

   // Per-register implemented-bit mask; register 3 lacks its bits 7-4 field.
   function automatic logic [15:0] impl_mask(input int idx);
      return (idx == 3) ? MASK_TIMER6 : MASK_FULL;
   endfunction

   logic [NUM_REGS-1:0] sel_hit;
   logic                access;
   logic                wr_en;
   logic [15:0]         regs [NUM_REGS];
   logic [15:0]         next_regs [NUM_REGS];
   logic [15:0]         rd_mux;
   prio_levels_t        lvl_next;
   logic [18:0]         lvl_flat_nz;

   assign sel_hit = decode(paddr);
   assign access  = psel && penable && pready;
   assign wr_en   = access && pwrite && (sel_hit != '0);

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------

   // Each register stores only its implemented bits, so empty positions
   // cannot hold a written one. Byte strobes gate the two low lanes.
   // The next value is formed once and feeds both the register and the
   // arbiter copy, so the copy never trails the register by a cycle.
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         localparam logic [15:0] MASK_G  = (g == 3) ? MASK_TIMER6 : MASK_FULL;
         localparam logic [15:0] RESET_G = (g == 3) ? RESET_TIMER6 : RESET_FULL;

         // Merge of the enabled byte lanes; each lane uses its own mask half.
         always_comb begin
            next_regs[g] = regs[g];
            if (wr_en && sel_hit[g]) begin
               if (pstrb[0]) begin
                  next_regs[g][7:0] = pwdata[7:0] & MASK_G[7:0];
               end
               if (pstrb[1]) begin
                  next_regs[g][15:8] = pwdata[15:8] & MASK_G[15:8];
               end
            end
         end

         // Storage; it changes only at the edge where an access completes.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               regs[g] <= RESET_G;
            end else begin
               regs[g] <= next_regs[g];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // APB answer
   // ---------------------------------------------------------------

   // Read mux; masked again so empty bits are zero whatever is stored.
   always_comb begin
      rd_mux = 16'h0000;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (sel_hit[i]) begin
            rd_mux = regs[i] & impl_mask(i);
         end
      end
   end

   // Answers take one wait state: pready rises at the edge that ends the first access cycle.
   // A registered pready costs a cycle but keeps every output off a gate.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   // Read data and error are registered alongside pready.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= READ_ZERO;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         prdata  <= pwrite ? READ_ZERO : {16'h0000, rd_mux};
         pslverr <= (sel_hit == '0);
      end else begin
         prdata  <= READ_ZERO;
         pslverr <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Field outputs to the arbiter
   // ---------------------------------------------------------------

   // Field extraction from the next register values, one source a field.
   always_comb begin
      lvl_next.can1_event_level       = next_regs[0][FIELD_POS3 +: FIELD_W];
      lvl_next.can1_receive_level     = next_regs[0][FIELD_POS2 +: FIELD_W];
      lvl_next.spi_port2_event_level  = next_regs[0][FIELD_POS1 +: FIELD_W];
      lvl_next.spi_port2_error_level  = next_regs[0][FIELD_POS0 +: FIELD_W];
      lvl_next.capture5_level         = next_regs[1][FIELD_POS3 +: FIELD_W];
      lvl_next.capture4_level         = next_regs[1][FIELD_POS2 +: FIELD_W];
      lvl_next.capture3_level         = next_regs[1][FIELD_POS1 +: FIELD_W];
      lvl_next.dma_ch3_done_level     = next_regs[1][FIELD_POS0 +: FIELD_W];
      lvl_next.compare7_level         = next_regs[2][FIELD_POS3 +: FIELD_W];
      lvl_next.compare6_level         = next_regs[2][FIELD_POS2 +: FIELD_W];
      lvl_next.compare5_level         = next_regs[2][FIELD_POS1 +: FIELD_W];
      lvl_next.capture6_level         = next_regs[2][FIELD_POS0 +: FIELD_W];
      lvl_next.timer6_level           = next_regs[3][FIELD_POS3 +: FIELD_W];
      lvl_next.dma_ch4_done_level     = next_regs[3][FIELD_POS2 +: FIELD_W];
      lvl_next.compare8_level         = next_regs[3][FIELD_POS0 +: FIELD_W];
      lvl_next.timer8_level           = next_regs[4][FIELD_POS3 +: FIELD_W];
      lvl_next.i2c_port2_master_level = next_regs[4][FIELD_POS2 +: FIELD_W];
      lvl_next.i2c_port2_slave_level  = next_regs[4][FIELD_POS1 +: FIELD_W];
      lvl_next.timer7_level           = next_regs[4][FIELD_POS0 +: FIELD_W];
   end

   // Levels are registered copies so outputs come from flip-flops. They
   // load from the same next value as the registers, at the same edge,
   // so the arbiter sees a new level with no cycle of extra lag.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         levels <= {19{LEVEL_RESET}};
      end else begin
         levels <= lvl_next;
      end
   end

   // A zero level withdraws the source; levels 1..7 order it, 7 highest.
   // Bit k of the flag vector lines up with field k of the level struct.
   generate
      for (g = 0; g < 19; g++) begin : g_nz
         assign lvl_flat_nz[g] = (lvl_next[FIELD_W * g +: FIELD_W] != LEVEL_DISABLED);
      end
   endgenerate

   // Enable flags load with the levels, so the two never disagree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enables <= '1;
      end else begin
         enables <= lvl_flat_nz;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------

   sequence s_write_reg0;
      psel && penable && pready && pwrite && (paddr == OFS_CAN1_SPI2) && pstrb[1];
   endsequence

   sequence s_write_reg3;
      psel && penable && pready && pwrite && (paddr == OFS_TIMER6_DMA4_CMP8) && pstrb[1];
   endsequence

   sequence s_access_first;
      psel && penable && !pready;
   endsequence

   sequence s_access_done;
      psel && penable && pready;
   endsequence

   a_write_reaches_level: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_reg0 |=> levels.can1_event_level == $past(pwdata[14:12]))
      else $error("written CAN event level did not reach output");

   a_timer6_reaches: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_reg3 |=> levels.timer6_level == $past(pwdata[14:12]))
      else $error("written timer 6 level did not reach output");

   a_pready_wait: assert property (@(posedge pclk) disable iff (!presetn)
      s_access_first |=> pready)
      else $error("pready did not follow the first access cycle");

   a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready stood longer than one cycle");

   a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> (prdata == READ_ZERO) && !pslverr)
      else $error("read data or error shown outside an answer");

   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && (sel_hit == '0) |=> pslverr)
      else $error("unmapped access gave no error");

   a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && (sel_hit != '0) |=> !pslverr)
      else $error("mapped access gave an error");

   a_unmapped_kept: assert property (@(posedge pclk) disable iff (!presetn)
      s_access_done ##0 (sel_hit == '0) |=> $stable(levels))
      else $error("unmapped access changed a level");

   a_lane_high_kept: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && (paddr == OFS_CAN1_SPI2) && !pstrb[1]
         |=> $stable(levels.can1_event_level))
      else $error("masked high lane changed the CAN event level");

   a_write_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && pwrite |=> prdata == READ_ZERO)
      else $error("write answer carried read data");

   a_reset_enables: assert property (@(posedge pclk)
      !presetn |=> (enables == 19'h7_ffff) || !presetn)
      else $error("sources not enabled after reset");

   a_enable_compare8: assert property (@(posedge pclk) disable iff (!presetn)
      (levels.compare8_level != LEVEL_DISABLED) |-> enables.compare8)
      else $error("nonzero compare 8 level left source disabled");

   a_map_dma4: assert property (@(posedge pclk) disable iff (!presetn)
      levels.dma_ch4_done_level == regs[3][10:8])
      else $error("DMA 4 map wrong");

   a_map_timer8: assert property (@(posedge pclk) disable iff (!presetn)
      levels.timer8_level == regs[4][14:12])
      else $error("timer 8 map wrong");

   a_empty_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> (prdata[31:16] == 16'h0000) && (prdata[15] == 1'b0) && (prdata[11] == 1'b0)
         && (prdata[7] == 1'b0) && (prdata[3] == 1'b0))
      else $error("unimplemented read bits not zero");

   a_reg3_gap_zero: assert property (@(posedge pclk) disable iff (!presetn)
      regs[3][7:3] == 5'h00)
      else $error("register 3 gap bits hold ones");

   a_zero_disables: assert property (@(posedge pclk) disable iff (!presetn)
      (levels.timer7_level == LEVEL_DISABLED) && $stable(levels.timer7_level)
         |-> !enables.timer7)
      else $error("zero level left source enabled");

   a_nonzero_enables: assert property (@(posedge pclk) disable iff (!presetn)
      (levels.capture3_level != LEVEL_DISABLED) && $stable(levels.capture3_level)
         |-> enables.capture3)
      else $error("nonzero level did not enable source");

   a_readback_last: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && !pwrite && (paddr == OFS_TIMERS_I2C2)
         |=> prdata[15:0] == $past(regs[4]))
      else $error("read did not return stored value");

   a_field_map_spi: assert property (@(posedge pclk) disable iff (!presetn)
      levels.spi_port2_error_level == regs[0][2:0])
      else $error("SPI error level mapped wrongly");

   a_field_map_i2c: assert property (@(posedge pclk) disable iff (!presetn)
      levels.i2c_port2_slave_level == regs[4][6:4])
      else $error("I2C slave level mapped wrongly");

   a_reset_level4: assert property (@(posedge pclk)
      !presetn |=> (levels.capture5_level == LEVEL_RESET) || !presetn)
      else $error("level not 4 after reset");

   a_map_capture6: assert property (@(posedge pclk) disable iff (!presetn)
      levels.capture6_level == regs[2][2:0] &&
          levels.compare7_level == regs[2][14:12])
      else $error("compare/capture map wrong");

   a_map_capture5: assert property (@(posedge pclk) disable iff (!presetn)
      levels.capture5_level == regs[1][14:12])
      else $error("capture 5 map wrong");

   a_map_can_rx: assert property (@(posedge pclk) disable iff (!presetn)
      levels.can1_receive_level == regs[0][10:8])
      else $error("CAN receive map wrong");

endmodule

// ### prio_regs_tb.sv
// Self-checking testbench for the priority register bank.
`timescale 1ns/1ps
module prio_regs_tb
   import prio_pkg::*;
;
   logic          pclk;
   logic          presetn;
   logic          psel;
   logic          penable;
   logic          pwrite;
   logic [11:0]   paddr;
   logic [31:0]   pwdata;
   logic [3:0]    pstrb;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   prio_levels_t  levels;
   prio_enables_t enables;
   int            fail_count;
   int            cmp_count;
   logic [15:0]   pat [5];
   logic [11:0]   offs [5];
   logic [31:0]   rd;
   logic          err;

   prio_regs i_dut (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .levels  (levels),
      .enables (enables)
   );

   // ------------------------------------------------------------
   // Clock and helpers
   // ------------------------------------------------------------
   // Free-running 100 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d.", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Compares one value with case equality so an unknown never matches.
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; the wait for pready is bounded so a hang ends the run.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         $display("ERROR pready expected 1 seen %b", pready);
         end_of_test();
      end
   endtask

   // Expected levels as one packed vector, first source in the top bits.
   function automatic logic [56:0] exp_lv();
      logic [56:0] v;
      v = '0;
      for (int i = 0; i < 5; i++) begin
         for (int f = 3; f >= 0; f--) begin
            if (!(i == 3 && f == 1)) begin
               v = {v[53:0], pat[i][4*f+:3]};
            end
         end
      end
      return v;
   endfunction

   // A source is enabled exactly when its level is nonzero.
   function automatic logic [18:0] en_of(input logic [56:0] l);
      logic [18:0] e;
      for (int k = 0; k < 19; k++) begin
         e[k] = |l[3*k+:3];
      end
      return e;
   endfunction

   // Reads all registers and the arbiter outputs after a reset.
   task automatic chk_reset();
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, offs[i], 32'h0000_0000, 4'h0, rd, err);
         chk("reset_value", 64'(i == 3 ? RESET_TIMER6 : RESET_FULL), 64'(rd));
      end
      chk("reset_levels", 64'({19{3'h4}}), 64'(levels));
      chk("reset_enables", 64'({19{1'b1}}), 64'(enables));
   endtask

   // Applies reset for six clock cycles.
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   // Patterns hold zeros, ones and sevens so disabled and extreme levels appear.
   initial begin
      presetn    = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 12'h000;
      pwdata     = 32'h0000_0000;
      pstrb      = 4'h0;
      fail_count = 0;
      cmp_count  = 0;
      offs = '{OFS_CAN1_SPI2, OFS_CAPTURE_DMA3, OFS_COMPARE_CAPTURE6,
               OFS_TIMER6_DMA4_CMP8, OFS_TIMERS_I2C2};
      pat  = '{16'h7010, 16'h2345, 16'h6701, 16'h3506, 16'h4320};
      do_reset();
      chk_reset();
      $display("Test reset values finished.");
      // Writes set every unimplemented bit and junk in the upper half.
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, offs[i], {16'hffff, pat[i] | (i == 3 ? 16'h88f8 : 16'h8888)}, 4'hf, rd, err);
         chk("write_err", 64'h0000_0000_0000_0000, 64'(err));
      end
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, offs[i], 32'h0000_0000, 4'h0, rd, err);
         chk("readback", 64'(pat[i]), 64'(rd));
      end
      repeat (2) @(posedge pclk);
      chk("levels", 64'(exp_lv()), 64'(levels));
      chk("enables", 64'(en_of(exp_lv())), 64'(enables));
      $display("Test field map finished.");
      // Byte lanes: low lane only, high lane only, then the unused lanes.
      apb(1'b1, OFS_CAN1_SPI2, 32'h0000_7777, 4'b0001, rd, err);
      pat[0] = 16'h7077;
      apb(1'b1, OFS_CAN1_SPI2, 32'h0000_0000, 4'b0010, rd, err);
      pat[0] = 16'h0077;
      apb(1'b1, OFS_CAN1_SPI2, 32'hffff_ffff, 4'b1100, rd, err);
      apb(1'b0, OFS_CAN1_SPI2, 32'h0000_0000, 4'h0, rd, err);
      chk("lane_readback", 64'(pat[0]), 64'(rd));
      chk("lane_levels", 64'(exp_lv()), 64'(levels));
      $display("Test byte lanes finished.");
      // An unmapped place must not disturb any field.
      apb(1'b1, 12'h014, 32'h0000_0000, 4'hf, rd, err);
      chk("unmapped_werr", 64'h0000_0000_0000_0001, 64'(err));
      apb(1'b0, 12'h014, 32'h0000_0000, 4'h0, rd, err);
      chk("unmapped_rd", 64'(READ_ZERO), 64'(rd));
      chk("unmapped_rerr", 64'h0000_0000_0000_0001, 64'(err));
      repeat (2) @(posedge pclk);
      chk("levels_kept", 64'(exp_lv()), 64'(levels));
      chk("enables_kept", 64'(en_of(exp_lv())), 64'(enables));
      $display("Test unmapped access finished.");
      // A second reset in mid-run must restore every field.
      do_reset();
      chk_reset();
      $display("Test second reset finished.");
      end_of_test();
   end
endmodule
